// ---- pkg/duic_pkg.sv ----
// Constants for the two-port serial glue block: offsets, fields, resets.
// Assumes an 8-bit I/O slave port with byte offsets from the card base.
package duic_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] DUIC_OFF_CHAN_ENABLE   = 8'h05;
  localparam logic [7:0] DUIC_OFF_CHAN_STATUS   = 8'h07;
  localparam logic [7:0] DUIC_OFF_CHAN_POLARITY = 8'h2A;
  localparam logic [7:0] DUIC_OFF_A_DATA        = 8'hC0;
  localparam logic [7:0] DUIC_OFF_A_IRQ_ENABLE  = 8'hC4;
  localparam logic [7:0] DUIC_OFF_A_CLOCK_SEL   = 8'hDC;
  localparam logic [7:0] DUIC_OFF_B_DATA        = 8'hE0;
  localparam logic [7:0] DUIC_OFF_B_IRQ_ENABLE  = 8'hE4;
  localparam logic [7:0] DUIC_OFF_B_CLOCK_SEL   = 8'hFC;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         DUIC_SPEED_BIT       = 1;
  localparam int         DUIC_IER_WIDTH       = 4;
  localparam logic [1:0] DUIC_CHAN_EN_RESET   = 2'h0;
  localparam logic [1:0] DUIC_CHAN_POL_RESET  = 2'h0;
  localparam logic [3:0] DUIC_IER_RESET       = 4'h0;
  localparam logic       DUIC_SPEED_RESET     = 1'b0;

  // Reference clock rates in Hz
  localparam int DUIC_REF_LOW_HZ  = 1843200;
  localparam int DUIC_REF_HIGH_HZ = 14745600;

  // Source hold time for identification, and its count at 250 MHz
  localparam int DUIC_CLK_HZ      = 250000000;
  localparam int DUIC_HOLD_MS     = 20;
  localparam int DUIC_HOLD_CYCLES = DUIC_CLK_HZ / 1000 * DUIC_HOLD_MS;

endpackage : duic_pkg

// ---- pkg/duic_chan_if.sv ----
// Interface carrying one channel's gating controls and result.
// Assumes source and controls are in the clk domain.
`timescale 1ns/1ns
interface duic_chan_if;
  logic enable;
  logic polarity;
  logic source;
  logic gated;
  modport ctrl (output enable, output polarity, output source, input gated);
  modport gate (input enable, input polarity, input source, output gated);
endinterface : duic_chan_if

// ---- hw/duic_gate.sv ----
// One interrupt channel: polarity select then enable gate, registered.
// Assumes the source has already been synchronised to clk.
`timescale 1ns/1ns
module duic_gate (
  input  wire logic  clk,
  input  wire logic  rst_n,
  duic_chan_if.gate  ch
);
  import duic_pkg::*;

  wire logic selected;

  // Polarity 0 passes the inverted line, 1 passes it straight
  assign selected = ch.polarity ? ch.source : ~ch.source;  // see RULE9

  // Registered so the merged output is glitch free
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch.gated <= 1'b0;
    end else begin
      ch.gated <= ch.enable & selected;  // see RULE8 see RULE18
    end
  end

endmodule : duic_gate

// ---- hw/duic_top.sv ----
// Two-port serial glue: interrupt gating/merge, speed select, UART window.
// Assumes a synchronous 8-bit I/O port on clk; UART cores sit outside.
//
// Behaviour
// RULE1 - Speed register bit 1 low selects the 1.8432 MHz UART reference.
// RULE2 - Writing 2 selects the 14.7456 MHz reference; each port own offset.
// RULE3 - Two sources: UART A interrupt feeds channel A, UART B feeds B.
// RULE4 - Merged host interrupt is level, active low; one pulse, one interrupt.
// RULE5 - Held low merged output keeps interrupting the host.
// RULE6 - Software sets channels to idle low and pulse high.
// RULE7 - Simultaneous channels assert the merged output once; equal priority.
// RULE8 - Enable bit 0 disables a channel, 1 enables it.
// RULE9 - Polarity 0 passes inverted UART interrupt, 1 passes it straight.
// RULE10 - Service code toggles polarity to end a held level.
// RULE11 - Service code reads all status, then services A, then B.
// RULE12 - A source should stay active about 20 ms for identification.
// RULE13 - Data offset read returns received byte, write loads transmit byte.
// RULE14 - UART interrupt enable holds four enables; bits 7 to 4 read zero.
// RULE15 - Both channel enables reset to 0.
// RULE16 - Status register shows gated channel levels.
// RULE17 - Polarity bits live in their own register.
// RULE18 - Gated channel is enable AND selected source; any high drives low.
// RULE19 - Only speed bit 1 matters; both ports reset to low speed.
`timescale 1ns/1ns
module duic_top (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] io_addr,
  input  wire logic       io_rd,
  input  wire logic       io_wr,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  input  wire logic       uart_a_irq_source,
  input  wire logic       uart_b_irq_source,
  input  wire logic [7:0] uart_a_receive_buffer,
  input  wire logic [7:0] uart_b_receive_buffer,
  output logic      [7:0] uart_a_transmit_holding,
  output logic      [7:0] uart_b_transmit_holding,
  output logic            uart_a_tx_load,
  output logic            uart_b_tx_load,
  output logic            uart_a_rx_take,
  output logic            uart_b_rx_take,
  output logic      [3:0] uart_a_irq_enable,
  output logic      [3:0] uart_b_irq_enable,
  output logic            uart_a_high_speed,
  output logic            uart_b_high_speed,
  output logic            host_irq_n
);
  import duic_pkg::*;

  // ****************************************
  // Source synchronisers
  // ****************************************
  logic [1:0] src_meta;
  logic [1:0] src_sync;

  // Pins from the UARTs pass two flops; only src_sync is read beyond
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_meta <= 2'h0;
      src_sync <= 2'h0;
    end else begin
      src_meta <= {uart_b_irq_source, uart_a_irq_source};  // see RULE3
      src_sync <= src_meta;
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  logic [1:0] chan_enable;
  logic [1:0] chan_polarity;
  logic       chan_a_enable;
  logic       chan_b_enable;
  logic       chan_a_polarity;
  logic       chan_b_polarity;
  logic       gated_chan_a;
  logic       gated_chan_b;

  assign chan_a_enable   = chan_enable[0];
  assign chan_b_enable   = chan_enable[1];
  assign chan_a_polarity = chan_polarity[0];
  assign chan_b_polarity = chan_polarity[1];

  // ****************************************
  // Address decode
  // ****************************************
  wire logic hit_en   = (io_addr == DUIC_OFF_CHAN_ENABLE);
  wire logic hit_st   = (io_addr == DUIC_OFF_CHAN_STATUS);
  wire logic hit_pol  = (io_addr == DUIC_OFF_CHAN_POLARITY);
  wire logic hit_a_d  = (io_addr == DUIC_OFF_A_DATA);
  wire logic hit_a_ie = (io_addr == DUIC_OFF_A_IRQ_ENABLE);
  wire logic hit_a_cs = (io_addr == DUIC_OFF_A_CLOCK_SEL);
  wire logic hit_b_d  = (io_addr == DUIC_OFF_B_DATA);
  wire logic hit_b_ie = (io_addr == DUIC_OFF_B_IRQ_ENABLE);
  wire logic hit_b_cs = (io_addr == DUIC_OFF_B_CLOCK_SEL);

  // Register writes; controls reset disabled and low speed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_enable       <= DUIC_CHAN_EN_RESET;   // see RULE15
      chan_polarity     <= DUIC_CHAN_POL_RESET;
      uart_a_irq_enable <= DUIC_IER_RESET;
      uart_b_irq_enable <= DUIC_IER_RESET;
      uart_a_high_speed <= DUIC_SPEED_RESET;     // see RULE19
      uart_b_high_speed <= DUIC_SPEED_RESET;
    end else if (io_wr) begin
      if (hit_en)   chan_enable       <= io_wdata[1:0];  // see RULE8
      if (hit_pol)  chan_polarity     <= io_wdata[1:0];  // see RULE17
      if (hit_a_ie) uart_a_irq_enable <= io_wdata[DUIC_IER_WIDTH-1:0];  // see RULE14
      if (hit_b_ie) uart_b_irq_enable <= io_wdata[DUIC_IER_WIDTH-1:0];
      if (hit_a_cs) uart_a_high_speed <= io_wdata[DUIC_SPEED_BIT];  // see RULE1 see RULE2
      if (hit_b_cs) uart_b_high_speed <= io_wdata[DUIC_SPEED_BIT];  // see RULE19
    end
  end

  // Transmit bytes held in flops toward the UARTs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      uart_a_transmit_holding <= 8'h00;
      uart_b_transmit_holding <= 8'h00;
    end else if (io_wr) begin
      if (hit_a_d) uart_a_transmit_holding <= io_wdata;  // see RULE13
      if (hit_b_d) uart_b_transmit_holding <= io_wdata;
    end
  end

  // Strobes to the UART cores, one cycle with the access
  assign uart_a_tx_load = io_wr & hit_a_d;
  assign uart_b_tx_load = io_wr & hit_b_d;
  assign uart_a_rx_take = io_rd & hit_a_d;  // see RULE13
  assign uart_b_rx_take = io_rd & hit_b_d;

  // ****************************************
  // Read mux
  // ****************************************
  logic [7:0] next_rdata;

  // Unmapped offsets read zero; narrow fields pad with zero
  always_comb begin
    next_rdata = 8'h00;
    if (hit_en)   next_rdata = {6'h00, chan_enable};
    if (hit_st)   next_rdata = {6'h00, gated_chan_b, gated_chan_a};  // see RULE16
    if (hit_pol)  next_rdata = {6'h00, chan_polarity};
    if (hit_a_d)  next_rdata = uart_a_receive_buffer;
    if (hit_b_d)  next_rdata = uart_b_receive_buffer;
    if (hit_a_ie) next_rdata = {4'h0, uart_a_irq_enable};  // see RULE14
    if (hit_b_ie) next_rdata = {4'h0, uart_b_irq_enable};
    if (hit_a_cs) next_rdata = {6'h00, uart_a_high_speed, 1'b0};
    if (hit_b_cs) next_rdata = {6'h00, uart_b_high_speed, 1'b0};
  end

  // Read data registered, valid the cycle after io_rd
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Channel gating and merge
  // ****************************************
  duic_chan_if chan_a_if ();
  duic_chan_if chan_b_if ();

  assign chan_a_if.enable   = chan_a_enable;
  assign chan_a_if.polarity = chan_a_polarity;
  assign chan_a_if.source   = src_sync[0];  // see RULE12 level passes as long as held
  assign chan_b_if.enable   = chan_b_enable;
  assign chan_b_if.polarity = chan_b_polarity;
  assign chan_b_if.source   = src_sync[1];
  assign gated_chan_a       = chan_a_if.gated;
  assign gated_chan_b       = chan_b_if.gated;

  duic_gate u_gate_a (
    .clk   (clk),
    .rst_n (rst_n),
    .ch    (chan_a_if)
  );

  duic_gate u_gate_b (
    .clk   (clk),
    .rst_n (rst_n),
    .ch    (chan_b_if)
  );

  // OR merge: coincident channels give one low level, no priority
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_irq_n <= 1'b1;
    end else begin
      host_irq_n <= ~(gated_chan_a | gated_chan_b);  // see RULE4 see RULE5 see RULE7 see RULE18
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_chan_high;
    gated_chan_a || gated_chan_b;
  endsequence

  property p_merge;
    @(posedge clk) disable iff (!rst_n) s_chan_high |=> !host_irq_n;
  endproperty
  a_merge: assert property (p_merge) else $error("merged irq not low");  // see RULE18

  property p_held_low;
    @(posedge clk) disable iff (!rst_n) (gated_chan_a && gated_chan_b) [*3] |=> !host_irq_n;
  endproperty
  a_held_low: assert property (p_held_low) else $error("held channels lost");  // see RULE5

  property p_idle_high;
    @(posedge clk) disable iff (!rst_n) !(gated_chan_a || gated_chan_b) |=> host_irq_n;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("irq low while idle");  // see RULE4

  property p_disabled;
    @(posedge clk) disable iff (!rst_n) !chan_a_enable |=> !gated_chan_a;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channel fired");  // see RULE8

  property p_polarity;
    @(posedge clk) disable iff (!rst_n)
      chan_b_enable |=> gated_chan_b == ($past(chan_b_polarity) ~^ $past(src_sync[1]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity select wrong");  // see RULE9

  property p_speed;
    @(posedge clk) disable iff (!rst_n)
      io_wr && hit_a_cs |=> uart_a_high_speed == $past(io_wdata[1]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed bit not taken");  // see RULE2

  property p_ier_read;
    @(posedge clk) disable iff (!rst_n) io_rd && hit_a_ie |=> io_rdata[7:4] == 4'h0;
  endproperty
  a_ier_read: assert property (p_ier_read) else $error("ier high bits nonzero");  // see RULE14

  property p_status;
    @(posedge clk) disable iff (!rst_n)
      io_rd && hit_st |=> io_rdata[1:0] == $past({gated_chan_b, gated_chan_a});
  endproperty
  a_status: assert property (p_status) else $error("status mismatch");  // see RULE16

endmodule : duic_top

// ---- testbench/duic_host_model.sv ----
// Host side of the glue block: counts interrupts seen on the merged line.
// Assumes host_irq_n is registered on clk and active low.
`timescale 1ns/1ns
module duic_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic host_irq_n,
  output int        irq_count
);
  logic prev_n;

  // One interrupt per falling edge; a held level is not re-counted here
  always_ff @(posedge clk) begin
    prev_n <= host_irq_n;
    if (!rst_n) begin
      irq_count <= 0;
    end else if (prev_n && !host_irq_n) begin
      irq_count <= irq_count + 1;
    end
  end
endmodule : duic_host_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the glue block: registers, speed, interrupts.
// Assumes the package offsets and a one-cycle registered read answer.
`timescale 1ns/1ns
module tb_top;
  import duic_pkg::*;
  logic        clk, rst_n, io_rd, io_wr, src_a, src_b, a_hi, b_hi, irq_n, rd_pend;
  logic [7:0]  io_addr, io_wdata, io_rdata, rbuf_a, rbuf_b, thr_a, thr_b, off, d;
  logic [3:0]  ier_a, ier_b;
  logic [31:0] seed = 32'hA8A9;
  logic [7:0]  exp_q[$];
  int          errors, n_tests, cyc, irqs, n0;
  logic        tx_a, tx_b, rx_a, rx_b;
  int          n_txa, n_txb, n_rxa, n_rxb;

  duic_top dut_u (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .uart_a_irq_source(src_a), .uart_b_irq_source(src_b),
    .uart_a_receive_buffer(rbuf_a), .uart_b_receive_buffer(rbuf_b), .uart_a_transmit_holding(thr_a),
    .uart_b_transmit_holding(thr_b), .uart_a_tx_load(tx_a), .uart_b_tx_load(tx_b), .uart_a_rx_take(rx_a),
    .uart_b_rx_take(rx_b), .uart_a_irq_enable(ier_a), .uart_b_irq_enable(ier_b),
    .uart_a_high_speed(a_hi), .uart_b_high_speed(b_hi), .host_irq_n(irq_n));
  duic_host_model host_u (.clk(clk), .rst_n(rst_n), .host_irq_n(irq_n), .irq_count(irqs));

  // ****************************************
  // Clock, helpers and bus tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Strobes last one cycle; the next access starts a full cycle later
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) begin
      io_addr  = a;
      io_wdata = v;
      io_wr    = 1'b1;
    end
    @(negedge clk) io_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) begin
      io_addr = a;
      io_rd   = 1'b1;
      exp_q.push_back(e);
    end
    @(negedge clk) io_rd = 1'b0;
  endtask : rd

  task automatic settle();
    repeat (6) @(negedge clk);
  endtask : settle

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // Read answers land one edge after the strobe; compare with oldest note
  always @(posedge clk) rd_pend <= io_rd & rst_n;
  always @(negedge clk) begin
    if (rd_pend) check(io_rdata, exp_q.pop_front());
  end

  // Count UART strobes; each data access must give exactly one
  always @(posedge clk) begin
    if (rst_n) begin
      n_txa += tx_a;
      n_txb += tx_b;
      n_rxa += rx_a;
      n_rxb += rx_b;
    end
  end

  // Hang guard, far above the roughly 140 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      results();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {io_rd, io_wr, src_a, src_b, rst_n} = 5'h00;
    {io_addr, io_wdata, rbuf_a, rbuf_b} = 32'h0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check({7'h00, irq_n}, 8'h01);
    check({2'h0, a_hi, b_hi, ier_a}, 8'h00);
    rd(DUIC_OFF_CHAN_ENABLE, 8'h00);
    for (int i = 0; i < 2; i++) begin
      off = i ? DUIC_OFF_B_CLOCK_SEL : DUIC_OFF_A_CLOCK_SEL;
      wr(off, 8'h02);
      check({7'h00, i ? b_hi : a_hi}, 8'h01);
      rd(off, 8'h02);
      wr(off, 8'hFD);
      check({7'h00, i ? b_hi : a_hi}, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      d = 8'(xs() >> 8);
      wr(i[0] ? DUIC_OFF_B_IRQ_ENABLE : DUIC_OFF_A_IRQ_ENABLE, d);
      check({4'h0, i[0] ? ier_b : ier_a}, {4'h0, d[3:0]});
      rd(i[0] ? DUIC_OFF_B_IRQ_ENABLE : DUIC_OFF_A_IRQ_ENABLE, {4'h0, d[3:0]});
      wr(i[0] ? DUIC_OFF_B_DATA : DUIC_OFF_A_DATA, d);
      check(i[0] ? thr_b : thr_a, d);
      rbuf_a = ~d;
      rbuf_b = d;
      rd(i[0] ? DUIC_OFF_B_DATA : DUIC_OFF_A_DATA, i[0] ? d : ~d);
    end
    // Unmapped place: writes dropped, reads zero
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    // Straight polarity, only A enabled: B alone must stay silent
    wr(DUIC_OFF_CHAN_POLARITY, 8'h03);              // idle low, pulse high
    wr(DUIC_OFF_CHAN_ENABLE, 8'h01);
    src_b = 1'b1;
    settle();
    check({7'h00, irq_n}, 8'h01);
    rd(DUIC_OFF_CHAN_STATUS, 8'h00);
    src_a = 1'b1;                                   // held until identified
    settle();
    check({7'h00, irq_n}, 8'h00);
    rd(DUIC_OFF_CHAN_STATUS, 8'h01);
    {src_a, src_b} = 2'b00;
    settle();
    check({7'h00, irq_n}, 8'h01);
    // Both channels rise together: one interrupt only
    wr(DUIC_OFF_CHAN_ENABLE, 8'h03);
    n0 = irqs;
    {src_a, src_b} = 2'b11;
    settle();
    check({7'h00, irq_n}, 8'h00);
    rd(DUIC_OFF_CHAN_STATUS, 8'h03);
    check(8'(irqs - n0), 8'h01);
    // Service A, then B: invert each held level so the merged line ends
    wr(DUIC_OFF_CHAN_POLARITY, 8'h02);
    rd(DUIC_OFF_CHAN_STATUS, 8'h02);
    settle();
    check({7'h00, irq_n}, 8'h00);
    wr(DUIC_OFF_CHAN_POLARITY, 8'h00);
    settle();
    check({7'h00, irq_n}, 8'h01);
    rd(DUIC_OFF_CHAN_STATUS, 8'h00);
    {src_a, src_b} = 2'b00;
    wr(DUIC_OFF_CHAN_POLARITY, 8'h03);
    settle();
    // Inverted A with idle-low source gives a gated high
    wr(DUIC_OFF_CHAN_POLARITY, 8'h02);
    settle();
    check({7'h00, irq_n}, 8'h00);
    rd(DUIC_OFF_CHAN_POLARITY, 8'h02);
    wr(DUIC_OFF_CHAN_POLARITY, 8'h03);
    settle();
    check({7'h00, irq_n}, 8'h01);
    check(8'(n_txa), 8'h02);
    check(8'(n_txb), 8'h02);
    check(8'(n_rxa), 8'h02);
    check(8'(n_rxb), 8'h02);
    results();
  end
endmodule : tb_top
